/* File: timer_pkg.sv */
// Shared constants, register map and carrier types of the multi-mode delay timer
package timer_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;       // Function select
  localparam logic [7:0] ADDR_SET_TIME = 8'h04;   // Set time in ticks
  localparam logic [7:0] ADDR_PULSE_TIME = 8'h08; // One-shot time in ticks
  localparam logic [7:0] ADDR_PRESCALE = 8'h0C;   // Tick divisor minus one
  localparam logic [7:0] ADDR_STATUS = 8'h10;     // Output, state, pin levels
  localparam logic [7:0] ADDR_COUNT = 8'h14;      // Elapsed ticks

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int MODE_W = 4;          // Width of the function field
  localparam int STAT_OUT_BIT = 0;    // Relay output level
  localparam int STAT_STATE_LSB = 1;  // Three bits of sequencer state
  localparam int STAT_POWER_BIT = 4;  // Supply present
  localparam int STAT_START_BIT = 5;  // Start level
  localparam int STAT_RESET_BIT = 6;  // Reset level

  // ----------------------------------------------------------------
  // Timing function codes
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_CYCLE_ON = 4'h0;    // Power start, on first
  localparam logic [3:0] MODE_RETRIG = 4'h1;      // Retriggerable one-shot
  localparam logic [3:0] MODE_NONRETRIG = 4'h2;   // Plain one-shot
  localparam logic [3:0] MODE_CYCLE_OFF = 4'h3;   // Signal start, off first
  localparam logic [3:0] MODE_OS_CYCLE = 4'h4;    // Off, on, then off
  localparam logic [3:0] MODE_ONOFF1 = 4'h5;      // Signal on/off-delay 1
  localparam logic [3:0] MODE_ONOFF3 = 4'h6;      // Signal on/off-delay 3
  localparam logic [3:0] MODE_PWR_DELAY = 4'h7;   // Power-up one-shot on-delay
  localparam logic [3:0] MODE_ONOFF2 = 4'h8;      // Signal on/off-delay 2
  localparam logic [3:0] MODE_OFFD1 = 4'h9;       // Signal off-delay 1
  localparam logic [3:0] MODE_OFFD2 = 4'hA;       // Signal off-delay 2
  localparam logic [3:0] MODE_DLY_PULSE = 4'hB;   // Delayed one-shot output

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_RST = MODE_RETRIG;          // Signal mode, idle
  localparam logic [31:0] SET_TIME_RST = 32'h0000_0064;   // 100 ticks
  localparam logic [31:0] PULSE_TIME_RST = 32'h0000_000A; // 10 ticks
  localparam logic [31:0] PRESCALE_RST = 32'h0000_00C7;   // 200 clocks a tick

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic power; // Supply present
    logic rstIn; // Reset input asserted
    logic start; // Start input asserted
  } pinLevel_t;

  typedef struct packed {
    logic startRise; // Start asserted this cycle
    logic startFall; // Start removed this cycle
  } pinEdge_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FIRST,
    ST_SECOND,
    ST_HOLD,
    ST_DONE
  } timerState_t;

endpackage

/* File: input_cond.sv */
// Pin synchronisers, start edge detection and the timebase prescaler
`timescale 1ns/10ps
module input_cond #(
  parameter int PRE_W = 16 // Width of the prescaler divisor
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic startIn,
  input wire logic resetIn,
  input wire logic powerIn,
  input wire logic [PRE_W-1:0] prescale,
  output timer_pkg::pinLevel_t level,
  output timer_pkg::pinEdge_t edges,
  output logic tick
);

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic [2:0] rawPins;   // Power, reset, start as they arrive
  logic [2:0] meta_reg;  // First stage, read only by the second
  logic [2:0] sync_reg;  // Second stage, safe to use
  logic prevStart_reg;   // Start one cycle back, for edges
  logic [PRE_W-1:0] preCnt_reg; // Clocks into the current tick
  logic [PRE_W-1:0] preCnt_next;
  logic tick_reg;
  logic tick_next;

  assign rawPins = {powerIn, resetIn, startIn};

  // Two flops per pin; metastability settles before anyone looks
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          meta_reg[g] <= 1'b0;
          sync_reg[g] <= 1'b0;
        end else begin
          meta_reg[g] <= rawPins[g];
          sync_reg[g] <= meta_reg[g];
        end
      end
    end
  endgenerate

  // Delayed copy of start for edge detection
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prevStart_reg <= 1'b0;
    end else begin
      prevStart_reg <= sync_reg[0];
    end
  end

  assign level = timer_pkg::pinLevel_t'(sync_reg);
  assign edges.startRise = sync_reg[0] & ~prevStart_reg; // R18
  assign edges.startFall = ~sync_reg[0] & prevStart_reg; // R18

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  // Held at zero without supply so the timebase restarts in phase
  always_comb begin
    preCnt_next = preCnt_reg + 1'b1;
    tick_next = 1'b0;
    if (!sync_reg[2]) begin
      preCnt_next = '0; // R2
    end else if (preCnt_reg >= prescale) begin
      preCnt_next = '0; // R17
      tick_next = 1'b1;
    end
  end

  // Register prescaler state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      preCnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      preCnt_reg <= preCnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule // input_cond

/* File: multi_mode_delay_timer.sv */
// Multi-mode delay timer: APB registers, sequencer and relay output
`timescale 1ns/10ps
// Function
// R1: Power-start cycle, on first, equal halves
// R2: Supply loss clears count, output, state
// R3: Retriggerable one-shot restarts on each start
// R4: Plain one-shot ignores starts while timing
// R5: Finished sequences accept next start directly; one-shot cycle and delayed one-shot stay in ST_DONE instead
// R6: Reset input aborts signal-start timing, output off
// R7: Signal-start cycle, off first, until reset
// R8: One-shot cycle: off, on, then off
// R9: On/off-delay 1: on-pulse at rise and fall
// R10: On/off-delay 3: delayed on, second start ends
// R11: Power-up delay off, then on until start
// R12: Each start forces off one preset time
// R13: On/off-delay 2: delayed on, off-delay after removal
// R14: Off-delay 1: on at start, time after removal
// R15: Off-delay 2: on-pulse after start removal
// R16: Delayed one-shot with separate pulse width time
// R17: Static function select, ticks of prescaled timebase
// R18: Inputs synchronised, edges found, reset beats start
// R19: Driver holds maintained starts, pulses momentary ones
module multi_mode_delay_timer #(
  parameter int CNT_W = 16, // Width of time registers and counter
  parameter int PRE_W = 16  // Width of the prescaler divisor
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic startIn,
  input wire logic resetIn,
  input wire logic powerIn,
  output logic relayOut
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  timer_pkg::pinLevel_t level;  // Synchronised pin levels
  timer_pkg::pinEdge_t edges;   // Start edges, one-cycle pulses
  logic tick;                   // One pulse per timebase period
  logic [3:0] mode_reg;         // Selected timing function
  logic [3:0] mode_next;
  logic [CNT_W-1:0] setTime_reg; // Set time in ticks
  logic [CNT_W-1:0] setTime_next;
  logic [CNT_W-1:0] pulseWidthTime_reg; // One-shot time in ticks
  logic [CNT_W-1:0] pulseWidthTime_next;
  logic [PRE_W-1:0] prescale_reg; // Timebase divisor minus one
  logic [PRE_W-1:0] prescale_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic accessFirst;  // First cycle of an access phase
  logic wrDone;       // Write completes at this edge
  logic modeWrite;    // Function being changed
  logic [31:0] readMux;
  timer_pkg::timerState_t state_reg;
  timer_pkg::timerState_t state_next;
  logic out_reg;      // Relay output
  logic out_next;
  logic [CNT_W-1:0] count_reg; // Ticks elapsed in the current period
  logic [CNT_W-1:0] count_next;
  logic [CNT_W-1:0] limit;     // Length of the current period
  logic [CNT_W:0] countPlus;   // Count after the pending tick
  logic expire;                // Current period ends now
  logic abort;                 // Return to idle, output off
  logic restart;               // Begin a fresh period

  // True for every offset that holds a register
  function automatic logic regHit(input logic [7:0] a);
    regHit = (a == timer_pkg::ADDR_CTRL) || (a == timer_pkg::ADDR_SET_TIME) ||
             (a == timer_pkg::ADDR_PULSE_TIME) || (a == timer_pkg::ADDR_PRESCALE) ||
             (a == timer_pkg::ADDR_STATUS) || (a == timer_pkg::ADDR_COUNT);
  endfunction

  // ----------------------------------------------------------------
  // Pin conditioning and timebase
  // ----------------------------------------------------------------
  input_cond #(
    .PRE_W(PRE_W)
  ) u_input_cond (
    .mclk(mclk),
    .rst_n(rst_n),
    .startIn(startIn),
    .resetIn(resetIn),
    .powerIn(powerIn),
    .prescale(prescale_reg),
    .level(level),
    .edges(edges),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // One wait state: pready rises the cycle after the access starts,
  // which keeps every bus output straight off a flop
  assign accessFirst = psel & penable & ~pready_reg;
  assign wrDone = psel & penable & pready_reg & pwrite;
  assign modeWrite = wrDone && (paddr == timer_pkg::ADDR_CTRL);

  // Read data selection; unmapped offsets read zero
  always_comb begin
    readMux = 32'h0000_0000;
    unique case (paddr)
      timer_pkg::ADDR_CTRL: readMux[3:0] = mode_reg;
      timer_pkg::ADDR_SET_TIME: readMux[CNT_W-1:0] = setTime_reg;
      timer_pkg::ADDR_PULSE_TIME: readMux[CNT_W-1:0] = pulseWidthTime_reg;
      timer_pkg::ADDR_PRESCALE: readMux[PRE_W-1:0] = prescale_reg;
      timer_pkg::ADDR_STATUS: begin
        readMux[timer_pkg::STAT_OUT_BIT] = out_reg;
        readMux[timer_pkg::STAT_STATE_LSB +: 3] = state_reg;
        readMux[timer_pkg::STAT_POWER_BIT] = level.power;
        readMux[timer_pkg::STAT_START_BIT] = level.start;
        readMux[timer_pkg::STAT_RESET_BIT] = level.rstIn;
      end
      timer_pkg::ADDR_COUNT: readMux[CNT_W-1:0] = count_reg;
      default: readMux = 32'h0000_0000;
    endcase
  end

  // Next values of bus outputs and writable registers
  always_comb begin
    pready_next = accessFirst;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    mode_next = mode_reg;
    setTime_next = setTime_reg;
    pulseWidthTime_next = pulseWidthTime_reg;
    prescale_next = prescale_reg;
    if (accessFirst) begin
      prdata_next = (!pwrite && regHit(paddr)) ? readMux : 32'h0000_0000;
      pslverr_next = ~regHit(paddr);
    end
    // Writes land only at the completing edge; read-only offsets ignore them
    if (wrDone) begin
      unique case (paddr)
        timer_pkg::ADDR_CTRL: mode_next = pwdata[3:0]; // R17
        timer_pkg::ADDR_SET_TIME: setTime_next = pwdata[CNT_W-1:0];
        timer_pkg::ADDR_PULSE_TIME: pulseWidthTime_next = pwdata[CNT_W-1:0];
        timer_pkg::ADDR_PRESCALE: prescale_next = pwdata[PRE_W-1:0];
        default: ;
      endcase
    end
  end

  // Register bus state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
      mode_reg <= timer_pkg::CTRL_RST;
      setTime_reg <= timer_pkg::SET_TIME_RST[CNT_W-1:0];
      pulseWidthTime_reg <= timer_pkg::PULSE_TIME_RST[CNT_W-1:0];
      prescale_reg <= timer_pkg::PRESCALE_RST[PRE_W-1:0];
    end else begin
      pready_reg <= pready_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
      mode_reg <= mode_next;
      setTime_reg <= setTime_next;
      pulseWidthTime_reg <= pulseWidthTime_next;
      prescale_reg <= prescale_next;
    end
  end

  // ----------------------------------------------------------------
  // Period measurement
  // ----------------------------------------------------------------
  // The delayed pulse uses its own width; all else runs on the set time
  assign limit = (state_reg == timer_pkg::ST_SECOND &&
                  mode_reg == timer_pkg::MODE_DLY_PULSE) ? pulseWidthTime_reg
                                                         : setTime_reg; // R16
  assign countPlus = {1'b0, count_reg} + 1'b1;
  // A zero time behaves as one tick; the first tick may be short since
  // starts are not aligned to the timebase
  assign expire = tick && (countPlus >= {1'b0, limit}); // R17

  // Supply loss always aborts; the reset pin spares only the power cycle
  assign abort = ~level.power | modeWrite |
                 (level.rstIn & (mode_reg != timer_pkg::MODE_CYCLE_ON)); // R2 R6 R18

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Next state, output and count for every timing function
  always_comb begin
    state_next = state_reg;
    out_next = out_reg;
    restart = 1'b0;
    count_next = count_reg;
    if (tick && (state_reg == timer_pkg::ST_FIRST || state_reg == timer_pkg::ST_SECOND)) begin
      count_next = countPlus[CNT_W-1:0];
    end
    if (abort) begin
      state_next = timer_pkg::ST_IDLE; // R2 R6
      out_next = 1'b0;
      restart = 1'b1;
    end else begin
      unique case (state_reg)
        // Waiting for power-up or a start; the output is off here
        timer_pkg::ST_IDLE: begin
          restart = 1'b1;
          if (mode_reg == timer_pkg::MODE_CYCLE_ON) begin
            state_next = timer_pkg::ST_FIRST; // R1
            out_next = 1'b1;
          end else if (mode_reg == timer_pkg::MODE_PWR_DELAY) begin
            state_next = timer_pkg::ST_FIRST; // R11
            out_next = 1'b0;
          end else if (edges.startRise) begin
            case (mode_reg)
              timer_pkg::MODE_RETRIG, timer_pkg::MODE_NONRETRIG,
              timer_pkg::MODE_ONOFF1: begin
                state_next = timer_pkg::ST_FIRST; // R3 R4 R9 R5
                out_next = 1'b1;
              end
              timer_pkg::MODE_CYCLE_OFF, timer_pkg::MODE_OS_CYCLE,
              timer_pkg::MODE_ONOFF3, timer_pkg::MODE_ONOFF2,
              timer_pkg::MODE_DLY_PULSE: begin
                state_next = timer_pkg::ST_FIRST; // R7 R8 R10 R13 R16 R5
                out_next = 1'b0;
              end
              timer_pkg::MODE_OFFD1: begin
                state_next = timer_pkg::ST_HOLD; // R14
                out_next = 1'b1;
              end
              timer_pkg::MODE_OFFD2: begin
                state_next = timer_pkg::ST_HOLD; // R15
                out_next = 1'b0;
              end
              // Unused codes keep the timer idle
              default: ;
            endcase
          end
        end
        // First timed period
        timer_pkg::ST_FIRST: begin
          case (mode_reg)
            timer_pkg::MODE_CYCLE_ON, timer_pkg::MODE_CYCLE_OFF: begin
              if (expire) begin
                out_next = ~out_reg; // R1 R7
                restart = 1'b1;
              end
            end
            timer_pkg::MODE_RETRIG: begin
              if (edges.startRise) begin
                restart = 1'b1; // R3
              end else if (expire) begin
                state_next = timer_pkg::ST_IDLE; // R3
                out_next = 1'b0;
              end
            end
            timer_pkg::MODE_OFFD1: begin
              if (edges.startRise) begin
                state_next = timer_pkg::ST_HOLD; // R14
              end else if (expire) begin
                state_next = timer_pkg::ST_IDLE; // R14
                out_next = 1'b0;
              end
            end
            timer_pkg::MODE_OS_CYCLE, timer_pkg::MODE_DLY_PULSE: begin
              if (expire) begin
                state_next = timer_pkg::ST_SECOND; // R8 R16
                out_next = 1'b1;
                restart = 1'b1;
              end
            end
            timer_pkg::MODE_ONOFF1: begin
              if (edges.startFall) begin
                state_next = timer_pkg::ST_SECOND; // R9
                restart = 1'b1;
              end else if (expire) begin
                state_next = timer_pkg::ST_HOLD; // R9
                out_next = 1'b0;
              end
            end
            timer_pkg::MODE_ONOFF2: begin
              if (edges.startFall) begin
                state_next = timer_pkg::ST_IDLE; // R13
              end else if (expire) begin
                state_next = timer_pkg::ST_HOLD; // R13
                out_next = 1'b1;
              end
            end
            timer_pkg::MODE_ONOFF3, timer_pkg::MODE_PWR_DELAY: begin
              if (expire) begin
                state_next = timer_pkg::ST_HOLD; // R10 R11 R12
                out_next = 1'b1;
              end
            end
            // Plain one-shot and off-delay 2: starts change nothing
            default: begin
              if (expire) begin
                state_next = timer_pkg::ST_IDLE; // R4 R15
                out_next = 1'b0;
              end
            end
          endcase
        end
        // Second timed period, output on
        timer_pkg::ST_SECOND: begin
          if (expire) begin
            out_next = 1'b0;
            if (mode_reg == timer_pkg::MODE_OS_CYCLE ||
                mode_reg == timer_pkg::MODE_DLY_PULSE) begin
              state_next = timer_pkg::ST_DONE; // R8 R16
            end else begin
              state_next = timer_pkg::ST_IDLE; // R9 R10 R13 R5
            end
          end
        end
        // Untimed hold, waiting for a start edge
        timer_pkg::ST_HOLD: begin
          restart = 1'b1;
          case (mode_reg)
            timer_pkg::MODE_ONOFF1, timer_pkg::MODE_ONOFF2: begin
              if (edges.startFall) begin
                state_next = timer_pkg::ST_SECOND; // R9 R13
                out_next = 1'b1;
              end
            end
            timer_pkg::MODE_ONOFF3: begin
              if (edges.startRise) begin
                state_next = timer_pkg::ST_SECOND; // R10
              end
            end
            timer_pkg::MODE_PWR_DELAY: begin
              if (edges.startRise) begin
                state_next = timer_pkg::ST_FIRST; // R12
                out_next = 1'b0;
              end
            end
            timer_pkg::MODE_OFFD1, timer_pkg::MODE_OFFD2: begin
              if (edges.startFall) begin
                state_next = timer_pkg::ST_FIRST; // R14 R15
                out_next = 1'b1;
              end
            end
            default: ;
          endcase
        end
        // Sequence over; only a reset, a function write or supply loss leaves this
        timer_pkg::ST_DONE: begin
          restart = 1'b1;
        end
      endcase
    end
    if (restart) begin
      count_next = '0;
    end
  end

  // Register sequencer state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= timer_pkg::ST_IDLE;
      out_reg <= 1'b0;
      count_reg <= '0;
    end else begin
      state_reg <= state_next;
      out_reg <= out_next;
      count_reg <= count_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign relayOut = out_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

endmodule // multi_mode_delay_timer

/* File: multi_mode_delay_timer_chk.sv */
// Port-level checker of the multi-mode delay timer and its bind
`timescale 1ns/10ps
module multi_mode_delay_timer_chk (
  input logic mclk,
  input logic rst_n,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic startIn,
  input logic resetIn,
  input logic powerIn,
  input logic relayOut
);
  // --------------------
  // Shadow of the function field, seen from completed writes
  // --------------------
  logic [3:0] modeReg; // Function now in force
  logic [3:0] modeNext; // Next value of the shadow
  // A write lands at the edge where pready is high
  always_comb begin
    modeNext = modeReg;
    if (psel && penable && pready && pwrite && paddr == timer_pkg::ADDR_CTRL) begin
      modeNext = pwdata[3:0];
    end
  end
  // Register only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      modeReg <= timer_pkg::CTRL_RST;
    end else begin
      modeReg <= modeNext;
    end
  end
  // --------------------
  // Properties
  // --------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_ready_answer: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered");
  a_ready_cause: assert property ($rose(pready) |-> $past(psel && penable))
    else $error("stray pready");
  a_error_form: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad error answer");
  a_power_idle: assert property (!powerIn [*6] |-> !relayOut)
    else $error("on without supply");
  a_reset_idle: assert property ((resetIn && modeReg != 4'h0) [*6] |-> !relayOut)
    else $error("on during reset");
  a_start_on: assert property (
    modeReg == timer_pkg::MODE_RETRIG && powerIn && !resetIn && $rose(startIn)
    |-> ##[1:6] relayOut)
    else $error("late one-shot");
  a_power_on: assert property (
    modeReg == timer_pkg::MODE_CYCLE_ON && $rose(powerIn) |-> ##[1:8] relayOut)
    else $error("late power cycle");
  c_refused: cover property (pslverr);
  c_oneshot_end: cover property ($fell(relayOut) && modeReg == timer_pkg::MODE_NONRETRIG);
  c_power_cycle: cover property ($rose(relayOut) && modeReg == timer_pkg::MODE_CYCLE_ON);
endmodule // multi_mode_delay_timer_chk

bind multi_mode_delay_timer multi_mode_delay_timer_chk u_chk (.mclk, .rst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .startIn, .resetIn, .powerIn, .relayOut);

/* File: multi_mode_delay_timer_tb_top.sv */
// Self-checking bench of the multi-mode delay timer
`timescale 1ns/10ps
`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin nFail++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module multi_mode_delay_timer_tb_top;
  localparam int S = 20; // Set time in ticks; prescale 0 gives one tick a clock
  logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic startIn = 0, resetIn = 0, powerIn = 1, pready, pslverr, relayOut;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  int nFail = 0;
  int nCompared = 0;
  always #2.5 mclk = ~mclk;
  multi_mode_delay_timer dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .startIn(startIn), .resetIn(resetIn), .powerIn(powerIn),
    .relayOut(relayOut));
  // Verdict and end of run
  task automatic completeRun();
    $display("Compared %0d, failed %0d", nCompared, nFail);
    if (nFail == 0 && nCompared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // One APB transfer, bounded wait for pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] eq, input logic ee);
    int n = 0;
    @(posedge mclk); psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge mclk); penable <= 1;
    do begin @(posedge mclk); n++; end while (pready !== 1'b1 && n < 50);
    `CHK("pready", 1'b1, pready)
    if (!wr) `CHK("prdata", eq, prdata)
    `CHK("pslverr", ee, pslverr)
    psel <= 0; penable <= 0;
  endtask
  // Bounded wait for an output level
  task automatic waitLvl(input logic v, output int n);
    n = 0;
    while (relayOut !== v && n < 500) begin @(posedge mclk); n++; end
  endtask
  // Length of the next stretch of relayOut at level v
  task automatic seg(input logic v, input int lo, input int hi);
    int n;
    waitLvl(v, n);
    n = 0;
    while (relayOut === v && n < 500) begin @(posedge mclk); n++; end
    `CHK("segment in range", 1'b1, n >= lo && n <= hi)
  endtask
  // Output steady for n cycles
  task automatic hold(input logic v, input int n);
    logic ok = 1;
    repeat (n) begin @(posedge mclk); if (relayOut !== v) ok = 0; end
    `CHK("steady level", 1'b1, ok)
  endtask
  // Momentary start, wide enough for the synchroniser
  task automatic pulse();
    @(posedge mclk) startIn <= 1;
    repeat (4) @(posedge mclk);
    startIn <= 0;
  endtask
  // Reset values, refused access, short timings
  task automatic tRegs();
    apb(0, timer_pkg::ADDR_CTRL, 0, timer_pkg::CTRL_RST, 0);
    apb(0, timer_pkg::ADDR_SET_TIME, 0, timer_pkg::SET_TIME_RST, 0);
    apb(0, timer_pkg::ADDR_PULSE_TIME, 0, timer_pkg::PULSE_TIME_RST, 0);
    apb(0, timer_pkg::ADDR_PRESCALE, 0, timer_pkg::PRESCALE_RST, 0);
    apb(0, 8'h20, 0, 32'h0, 1);
    apb(1, timer_pkg::ADDR_SET_TIME, S, 0, 0);
    apb(1, timer_pkg::ADDR_PULSE_TIME, 3, 0, 0);
    apb(1, timer_pkg::ADDR_PRESCALE, 0, 0, 0);
    apb(0, timer_pkg::ADDR_SET_TIME, 0, S, 0);
  endtask
  // A second start four cycles into the on time
  task automatic tOneShot(input logic [3:0] m, input int lo, input int hi);
    int n;
    apb(1, timer_pkg::ADDR_CTRL, m, 0, 0);
    pulse();
    waitLvl(1, n);
    repeat (3) @(posedge mclk);
    pulse();
    seg(1, lo, hi);
  endtask
  // One on stretch of len cycles, then off for 3 * S cycles
  task automatic tOnceOff(input logic [3:0] m, input int len);
    apb(1, timer_pkg::ADDR_CTRL, m, 0, 0);
    pulse();
    seg(1, len, len);
    hold(0, 3 * S);
  endtask
  // Cycling off first, stopped by the reset input
  task automatic tCycleOff();
    apb(1, timer_pkg::ADDR_CTRL, timer_pkg::MODE_CYCLE_OFF, 0, 0);
    pulse();
    seg(1, S, S);
    seg(0, S, S);
    @(posedge mclk) resetIn <= 1;
    repeat (6) @(posedge mclk);
    hold(0, 2 * S);
    resetIn <= 0;
  endtask
  // Maintained start keeps off, removal gives one on period
  task automatic tOffDelay2();
    apb(1, timer_pkg::ADDR_CTRL, timer_pkg::MODE_OFFD2, 0, 0);
    @(posedge mclk) startIn <= 1;
    hold(0, 2 * S);
    startIn <= 0;
    seg(1, S, S);
  endtask
  // Power-up delay, then one start forces one off period
  task automatic tPwrDelay();
    int n;
    apb(1, timer_pkg::ADDR_CTRL, timer_pkg::MODE_PWR_DELAY, 0, 0);
    waitLvl(1, n);
    `CHK("power-up delay", 1'b1, n >= S && n <= S + 6)
    hold(1, S);
    pulse();
    seg(0, S, S);
    hold(1, S);
  endtask
  // Supply loss clears, supply return cycles on first
  task automatic tPower();
    apb(1, timer_pkg::ADDR_CTRL, timer_pkg::MODE_CYCLE_ON, 0, 0);
    @(posedge mclk) powerIn <= 0;
    repeat (6) @(posedge mclk);
    hold(0, S);
    powerIn <= 1;
    seg(1, S, S);
    seg(0, S, S);
  endtask
  // Cuts a hang short
  initial begin
    #200000;
    nFail++;
    completeRun();
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1;
    tRegs();
    tOneShot(timer_pkg::MODE_RETRIG, S - 3, S + 2);
    tOneShot(timer_pkg::MODE_NONRETRIG, S - 9, S - 7);
    tOneShot(timer_pkg::MODE_NONRETRIG, S - 9, S - 7);
    tOnceOff(timer_pkg::MODE_OS_CYCLE, S);
    tOnceOff(timer_pkg::MODE_DLY_PULSE, 3);
    tOnceOff(timer_pkg::MODE_OFFD1, S + 4);
    tCycleOff();
    tOffDelay2();
    tPwrDelay();
    tPower();
    completeRun();
  end
endmodule // multi_mode_delay_timer_tb_top
